// File: src/compare_timer.sv
// Eight-bit compare timer with AXI4-Lite register access.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "timer_defines.svh"

module compare_timer (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  input  wire logic        EXT_COUNT_CLOCK_PIN,
  input  wire logic        EXT_COUNTER_RESET_PIN,
  input  wire logic        COUNT_TRIGGER_PIN,
  output logic             WAVEFORM_OUT_PIN,
  output logic             IRQ
);

  timer_pkg::timer_state_s st;
  timer_pkg::timer_state_s next_st;
  logic [`TMR_PRESCALE_BITS-1:0] div;

  // Returns {mapped, index} for a byte address.
  function automatic logic [3:0] decode(input logic [7:0] addr);
    case (addr)
      `TMR_OFF_COUNT:      decode = 4'h8;
      `TMR_OFF_CONST_A:    decode = 4'h9;
      `TMR_OFF_CONST_B:    decode = 4'ha;
      `TMR_OFF_CTL_FIRST:  decode = 4'hb;
      `TMR_OFF_STATUS:     decode = 4'hc;
      `TMR_OFF_CTL_SECOND: decode = 4'hd;
      `TMR_OFF_MASK:       decode = 4'he;
      default:             decode = 4'h0;
    endcase
  endfunction

  // Maps a two-bit output selection onto its action.
  function automatic timer_pkg::out_act_e action(input logic [1:0] sel);
    case (sel)
      2'h1:    action = timer_pkg::OUT_LOW;
      2'h2:    action = timer_pkg::OUT_HIGH;
      2'h3:    action = timer_pkg::OUT_TOGGLE;
      default: action = timer_pkg::OUT_KEEP;
    endcase
  endfunction

  // Applies the strongest of two output actions to the current level.
  function automatic logic resolve(input timer_pkg::out_act_e a,
                                   input timer_pkg::out_act_e b,
                                   input logic                cur);
    if (a == timer_pkg::OUT_TOGGLE || b == timer_pkg::OUT_TOGGLE) begin
      resolve = ~cur;
    end else if (a == timer_pkg::OUT_HIGH || b == timer_pkg::OUT_HIGH) begin
      resolve = 1'b1;
    end else if (a == timer_pkg::OUT_LOW || b == timer_pkg::OUT_LOW) begin
      resolve = 1'b0;
    end else begin
      resolve = cur;
    end
  endfunction

  timer_prescaler u_prescaler (
    .clk (MCLK),
    .rst (RST),
    .div (div)
  );

  logic                  sel_level;
  logic                  inc;
  logic                  do_wr;
  logic [3:0]            widx;
  logic [3:0]            ridx;
  logic                  wr_cnt;
  logic                  wr_cora;
  logic                  wr_corb;
  logic                  match_a;
  logic                  match_b;
  logic                  clr;
  logic                  rst_edge;
  logic                  trg_edge;
  logic [2:0]            set_flags;
  logic [2:0]            clr_flags;
  timer_pkg::out_act_e   act_a;
  timer_pkg::out_act_e   act_b;
  logic [7:0]            rd_val;
  logic                  wr_ctl_first;
  logic                  wr_status;
  logic                  wr_ctl_second;
  logic                  wr_mask;
  logic [2:0]            pin_in;
  logic [2:0][2:0]       sync_now;
  logic [2:0][2:0]       sync_next;
  logic [2:0]            level_now;
  logic [2:0]            level_next;

  // Pins pass three flops; a level counts once stages two and three agree.
  assign pin_in    = {COUNT_TRIGGER_PIN, EXT_COUNTER_RESET_PIN,
                      EXT_COUNT_CLOCK_PIN};
  assign sync_now  = {st.trg_sync, st.rst_sync, st.ext_sync};
  assign level_now = {st.trg_f, st.rst_f, st.ext_f};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    assign sync_next[i]  = {sync_now[i][1:0], pin_in[i]};
    assign level_next[i] = (sync_now[i][1] == sync_now[i][2])
                           ? sync_now[i][2] : level_now[i];
  end

  always_comb begin
    next_st = st;

    next_st.ext_sync = sync_next[0];
    next_st.rst_sync = sync_next[1];
    next_st.trg_sync = sync_next[2];
    next_st.ext_f    = level_next[0];
    next_st.rst_f    = level_next[1];
    next_st.trg_f    = level_next[2];
    rst_edge = level_next[1] & ~st.rst_f;
    trg_edge = level_next[2] & ~st.trg_f;

    // Selected clock level; a switch from high to low counts as a falling edge.
    case (st.cks)
      `TMR_CKS_STOP: sel_level = 1'b0;
      `TMR_CKS_EXT:  sel_level = st.ext_f;
      default:       sel_level = div[st.cks];
    endcase
    next_st.sel_prev = sel_level;
    inc = st.sel_prev & ~sel_level & (~st.trig_en | st.started);

    // Trigger arms counting while trigger gating is enabled.
    if (!st.trig_en) begin
      next_st.started = 1'b0;
    end else if (trg_edge) begin
      next_st.started = 1'b1;
    end

    // Register write takes effect in the cycle it completes.
    do_wr   = st.aw_held & st.w_held & ~st.bvalid & st.wstrb0;
    widx    = decode(st.awaddr);
    wr_cnt  = do_wr & (widx == 4'h8);
    wr_cora = do_wr & (widx == 4'h9);
    wr_corb = do_wr & (widx == 4'ha);
    wr_ctl_first  = do_wr & (widx == 4'hb);
    wr_status     = do_wr & (widx == 4'hc);
    wr_ctl_second = do_wr & (widx == 4'hd);
    wr_mask       = do_wr & (widx == 4'he);

    match_a = st.moved & (st.cnt == st.cora) & ~wr_cora;
    match_b = st.moved & (st.cnt == st.corb) & ~wr_corb;

    case (st.cclr)
      `TMR_CCLR_CMA: clr = match_a;
      `TMR_CCLR_CMB: clr = match_b;
      `TMR_CCLR_PIN: clr = rst_edge;
      default:       clr = 1'b0;
    endcase

    set_flags = 3'h0;
    set_flags[`TMR_FLAG_CMA_BIT] = match_a;
    set_flags[`TMR_FLAG_CMB_BIT] = match_b;
    if (clr) begin
      next_st.cnt = 8'h00;
    end else if (wr_cnt) begin
      next_st.cnt = st.wdata;
    end else if (inc) begin
      next_st.cnt = st.cnt + 8'h01;
      set_flags[`TMR_FLAG_OVERFLOW_BIT] = (st.cnt == 8'hff);
    end
    next_st.moved = (next_st.cnt != st.cnt);

    if (wr_cora) begin
      next_st.cora = st.wdata;
    end
    if (wr_corb) begin
      next_st.corb = st.wdata;
    end
    if (wr_ctl_first) begin
      next_st.cks  = st.wdata[`TMR_CKS_MSB:`TMR_CKS_LSB];
      next_st.cclr = st.wdata[`TMR_CCLR_MSB:`TMR_CCLR_LSB];
    end
    if (wr_ctl_second) begin
      next_st.trig_en = st.wdata[`TMR_TRIG_EN_BIT];
      next_st.osa     = st.wdata[`TMR_OSA_MSB:`TMR_OSA_LSB];
      next_st.osb     = st.wdata[`TMR_OSB_MSB:`TMR_OSB_LSB];
    end
    if (wr_mask) begin
      next_st.mask = st.wdata[2:0];
    end

    // Status bits clear by writing one; a new event wins over the clear.
    clr_flags = wr_status ? st.wdata[2:0] : 3'h0;
    next_st.flags = (st.flags & ~clr_flags) | set_flags;

    // Output action; toggle beats high, high beats low.
    act_a = match_a ? action(st.osa) : timer_pkg::OUT_KEEP;
    act_b = match_b ? action(st.osb) : timer_pkg::OUT_KEEP;
    next_st.wave = resolve(act_a, act_b, st.wave);

    // Write channel: address and data are held until both have arrived.
    if (AWVALID && AWREADY) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = WDATA[7:0];
      next_st.wstrb0 = WSTRB[0];
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = widx[3] ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel: data is captured at the address handshake.
    ridx = decode(ARADDR);
    case (ridx)
      4'h8:    rd_val = st.cnt;
      4'h9:    rd_val = st.cora;
      4'ha:    rd_val = st.corb;
      4'hb:    rd_val = {3'h0, st.cclr, st.cks};
      4'hc:    rd_val = {5'h00, st.flags};
      4'hd:    rd_val = {3'h0, st.osb, st.osa, st.trig_en};
      4'he:    rd_val = {5'h00, st.mask};
      default: rd_val = 8'h00;
    endcase
    if (ARVALID && ARREADY) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = ridx[3] ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end else if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st      <= '0;
      st.cnt  <= `TMR_RST_COUNT;
      st.cora <= `TMR_RST_CONST;
      st.corb <= `TMR_RST_CONST;
      st.cks     <= 3'(`TMR_RST_CTL);
      st.cclr    <= 2'(`TMR_RST_CTL);
      st.osa     <= 2'(`TMR_RST_CTL);
      st.osb     <= 2'(`TMR_RST_CTL);
      st.trig_en <= 1'(`TMR_RST_CTL);
      st.mask    <= 3'(`TMR_RST_CTL);
    end else begin
      st <= next_st;
    end
  end

  assign AWREADY          = ~st.aw_held & ~st.bvalid;
  assign WREADY           = ~st.w_held & ~st.bvalid;
  assign BVALID           = st.bvalid;
  assign BRESP            = st.bresp;
  assign ARREADY          = ~st.rvalid;
  assign RVALID           = st.rvalid;
  assign RDATA            = {24'h000000, st.rdata};
  assign RRESP            = st.rresp;
  assign WAVEFORM_OUT_PIN = st.wave;
  assign IRQ              = |(st.flags & st.mask);

endmodule

// File: inc/timer_defines.svh
// Offsets, field positions, reset values, prescaler width and response codes of the timer.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define TMR_OFF_COUNT      8'h00
`define TMR_OFF_CONST_A    8'h04
`define TMR_OFF_CONST_B    8'h08
`define TMR_OFF_CTL_FIRST  8'h0c
`define TMR_OFF_STATUS     8'h10
`define TMR_OFF_CTL_SECOND 8'h14
`define TMR_OFF_MASK       8'h18

`define TMR_RST_COUNT      8'h00
`define TMR_RST_CONST      8'hff
`define TMR_RST_CTL        8'h00

`define TMR_CKS_LSB        0
`define TMR_CKS_MSB        2
`define TMR_CCLR_LSB       3
`define TMR_CCLR_MSB       4
`define TMR_TRIG_EN_BIT    0
`define TMR_OSA_LSB        1
`define TMR_OSA_MSB        2
`define TMR_OSB_LSB        3
`define TMR_OSB_MSB        4
`define TMR_FLAG_CMA_BIT   0
`define TMR_FLAG_CMB_BIT   1
`define TMR_FLAG_OVERFLOW_BIT 2

`define TMR_CKS_STOP       3'h0
`define TMR_CKS_EXT        3'h7
`define TMR_CCLR_NONE      2'h0
`define TMR_CCLR_CMA       2'h1
`define TMR_CCLR_CMB       2'h2
`define TMR_CCLR_PIN       2'h3

`define TMR_PRESCALE_BITS  7
`define TMR_RESP_OKAY      2'h0
`define TMR_RESP_SLVERR    2'h2

`endif

// File: inc/timer_pkg.sv
// Types shared by the compare timer and its prescaler.
package timer_pkg;

  typedef enum logic [3:0] {
    OUT_KEEP   = 4'h1,
    OUT_LOW    = 4'h2,
    OUT_HIGH   = 4'h4,
    OUT_TOGGLE = 4'h8
  } out_act_e;

  typedef struct packed {
    logic [6:0] div;
  } prescale_state_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cora;
    logic [7:0] corb;
    logic [2:0] cks;
    logic [1:0] cclr;
    logic [1:0] osa;
    logic [1:0] osb;
    logic       trig_en;
    logic       started;
    logic [2:0] flags;
    logic [2:0] mask;
    logic       wave;
    logic       sel_prev;
    logic       moved;
    logic [2:0] ext_sync;
    logic [2:0] rst_sync;
    logic [2:0] trg_sync;
    logic       ext_f;
    logic       rst_f;
    logic       trg_f;
    logic       aw_held;
    logic [7:0] awaddr;
    logic       w_held;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } timer_state_s;

endpackage

// File: src/timer_prescaler.sv
// Free-running divider of the system clock for the internal count clocks.
`timescale 1ns/1ns
`include "timer_defines.svh"

module timer_prescaler (
  input  wire logic                           clk,
  input  wire logic                           rst,
  output logic [`TMR_PRESCALE_BITS-1:0]       div
);

  timer_pkg::prescale_state_s st;
  timer_pkg::prescale_state_s next_st;

  // Bit k of the divider is a square wave of period 2**(k+1) clocks.
  always_comb begin
    next_st     = st;
    next_st.div = st.div + 7'h01;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign div = st.div;

endmodule

// File: bench/timer_checks_assertions.sv
// Bus and interrupt assertions for the compare timer.
`timescale 1ns/1ns
module timer_checks (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence both_held;
    !AWREADY && !WREADY && !BVALID;
  endsequence
  sequence read_taken;
    ARVALID && ARREADY;
  endsequence
  write_answer_a: assert property (both_held |=> BVALID)
    else $error("write not answered");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  b_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken during response");
  b_code_a: assert property (BVALID |-> BRESP == 2'h0 || BRESP == 2'h2)
    else $error("bad write response code");
  read_answer_a: assert property (read_taken |=> RVALID)
    else $error("read not answered");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data changed");
  ar_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken during response");
  r_width_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data above eight bits");
  irq_fall_a: assert property ($fell(IRQ) |-> $rose(BVALID))
    else $error("interrupt fell without write");
endmodule

bind compare_timer timer_checks chk (.MCLK(MCLK), .RST(RST),
  .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .IRQ(IRQ));

// File: bench/ext_pins.sv
// Model of the external count clock, reset and trigger sources.
`timescale 1ns/1ns
module ext_pins (
  input wire logic clk,
  output logic     clk_pin,
  output logic     rst_pin,
  output logic     trg_pin
);
  initial clk_pin = 1'h0;
  initial rst_pin = 1'h0;
  initial trg_pin = 1'h0;
  task automatic hold();
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse_clock(input int n);
    repeat (n) begin
      clk_pin <= 1'h1;
      hold();
      clk_pin <= 1'h0;
      hold();
    end
  endtask
  task automatic pulse_reset();
    rst_pin <= 1'h1;
    hold();
    rst_pin <= 1'h0;
    hold();
  endtask
  task automatic pulse_trigger();
    trg_pin <= 1'h1;
    hold();
    trg_pin <= 1'h0;
    hold();
  endtask
endmodule

// File: bench/test_eight_bit_compare_timer.sv
// Self-checking bench for the compare timer.
`timescale 1ns/1ns
module test_eight_bit_compare_timer;
  logic        MCLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic        ARVALID = 0, RREADY = 0;
  logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0, d;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'hf;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, WAVE, IRQ;
  logic        EPC, EPR, EPT;
  logic [1:0]  BRESP, RRESP, r;
  int          n_errors = 0, check_count = 0;

  ext_pins p (.clk(MCLK), .clk_pin(EPC), .rst_pin(EPR), .trg_pin(EPT));
  compare_timer uut (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .EXT_COUNT_CLOCK_PIN(EPC), .EXT_COUNTER_RESET_PIN(EPR),
    .COUNT_TRIGGER_PIN(EPT), .WAVEFORM_OUT_PIN(WAVE), .IRQ(IRQ));

  always #50 MCLK = ~MCLK;

  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    logic aw_wait, w_wait, aw_go, w_go;
    @(posedge MCLK);
    aw_wait = 1'h1;
    w_wait = 1'h1;
    AWADDR <= a;
    WDATA <= {24'h0, v};
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    while (aw_wait || w_wait) begin
      @(negedge MCLK);
      aw_go = aw_wait && AWREADY;
      w_go = w_wait && WREADY;
      @(posedge MCLK);
      if (aw_go) begin
        AWVALID <= 1'h0;
        aw_wait = 1'h0;
      end
      if (w_go) begin
        WVALID <= 1'h0;
        w_wait = 1'h0;
      end
    end
    do @(negedge MCLK); while (!BVALID);
    r = BRESP;
    @(posedge MCLK);
    BREADY <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do @(negedge MCLK); while (!ARREADY);
    @(posedge MCLK);
    ARVALID <= 1'h0;
    do @(negedge MCLK); while (!RVALID);
    d = RDATA[7:0];
    r = RRESP;
    @(posedge MCLK);
    RREADY <= 1'h0;
  endtask
  task automatic rchk(input string s, input logic [7:0] a, e);
    rd(a);
    chk(s, e, d);
  endtask
  task automatic t_reset();
    rchk("count", 8'h00, 8'h00);
    rchk("const a", 8'h04, 8'hff);
    rchk("const b", 8'h08, 8'hff);
    rchk("ctl first", 8'h0c, 8'h00);
    rchk("status", 8'h10, 8'h00);
    rchk("ctl second", 8'h14, 8'h00);
    rchk("mask", 8'h18, 8'h00);
    rchk("unmapped", 8'h1c, 8'h00);
    chk("unmapped rd resp", 2'h2, r);
    wr(8'h1c, 8'h55);
    chk("unmapped wr resp", 2'h2, r);
    $display("test reset finished");
  endtask
  task automatic t_ext();
    wr(8'h04, 8'h05);
    wr(8'h08, 8'h05);
    wr(8'h14, 8'h12);
    wr(8'h0c, 8'h07);
    wr(8'h00, 8'h00);
    p.pulse_clock(5);
    @(negedge MCLK);
    chk("wave priority", 1'h1, WAVE);
    rchk("ext count", 8'h00, 8'h05);
    rchk("match flags", 8'h10, 8'h03);
    $display("test external clock finished");
  endtask
  task automatic t_int();
    wr(8'h10, 8'h07);
    wr(8'h14, 8'h06);
    wr(8'h04, 8'h10);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h0c, 8'h01);
    @(negedge MCLK);
    chk("irq idle", 1'h0, IRQ);
    repeat (80) @(negedge MCLK);
    chk("irq", 1'h1, IRQ);
    chk("toggle", 1'h0, WAVE);
    wr(8'h18, 8'h00);
    @(negedge MCLK);
    chk("irq masked", 1'h0, IRQ);
    wr(8'h18, 8'h01);
    wr(8'h10, 8'h07);
    @(negedge MCLK);
    chk("irq cleared", 1'h0, IRQ);
    wr(8'h00, 8'hfe);
    repeat (20) @(posedge MCLK);
    rd(8'h10);
    chk("overflow flag", 1'h1, d[2]);
    rd(8'h00);
    chk("wrapped", 1'h1, d < 8'h08);
    $display("test internal clock finished");
  endtask
  task automatic t_clear();
    wr(8'h04, 8'h03);
    wr(8'h0c, 8'h09);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h07);
    repeat (200) @(posedge MCLK);
    rd(8'h00);
    chk("match clear", 1'h1, d <= 8'h03);
    rd(8'h10);
    chk("no overflow", 1'h0, d[2]);
    wr(8'h08, 8'h02);
    wr(8'h0c, 8'h11);
    wr(8'h00, 8'h00);
    repeat (100) @(posedge MCLK);
    rd(8'h00);
    chk("match b clear", 1'h1, d <= 8'h02);
    wr(8'h0c, 8'h18);
    wr(8'h00, 8'h42);
    p.pulse_reset();
    rchk("pin clear", 8'h00, 8'h00);
    $display("test clearing finished");
  endtask
  task automatic t_trig();
    wr(8'h14, 8'h01);
    wr(8'h0c, 8'h07);
    wr(8'h00, 8'h00);
    p.pulse_clock(2);
    rchk("armed hold", 8'h00, 8'h00);
    p.pulse_trigger();
    p.pulse_clock(3);
    rchk("triggered", 8'h00, 8'h03);
    $display("test trigger finished");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'h0;
    t_reset();
    t_ext();
    t_int();
    t_clear();
    t_trig();
    give_verdict();
  end
  initial begin
    #2000000;
    n_errors++;
    give_verdict();
  end
endmodule
